// file: include/ifa_pkg.sv
// Purpose: shared constants and types for the two-wire byte-array slave
// Assumes: 2048 x 8 array, 3-bit page select joined above an 8-bit word address
// Notes:   all timing follows the serial clock edges, no fixed delays
package ifa_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned WORD_W    = 8;
    localparam int unsigned PAGE_W    = 3;
    localparam int unsigned ADDR_W    = PAGE_W + WORD_W;
    localparam int unsigned TYPE_W    = 4;
    localparam int unsigned SYNC_W    = 3;

    // slave address byte layout
    localparam int unsigned TYPE_MSB  = 7;
    localparam int unsigned TYPE_LSB  = 4;
    localparam int unsigned PAGE_MSB  = 3;
    localparam int unsigned PAGE_LSB  = 1;
    localparam int unsigned RW_BIT    = 0;

    localparam logic [2:0]        BIT_LAST   = 3'h7;
    localparam logic [2:0]        BIT_FIRST  = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
    localparam logic [ADDR_W-1:0] ADDR_TOP   = 11'h7FF;
    localparam logic [ADDR_W-1:0] ADDR_ONE   = 11'h001;

    // device-type nibble; value is arbitrary
    localparam logic [TYPE_W-1:0] TYPE_CODE_DEFAULT = 4'h5;

    // sync lanes: scl, sda, write protect; idle bus is high, protect is low
    localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h3;
    localparam int unsigned LANE_SCL  = 0;
    localparam int unsigned LANE_SDA  = 1;
    localparam int unsigned LANE_WP   = 2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_DEV   = 4'h1,
        ST_WORD  = 4'h2,
        ST_WDATA = 4'h3,
        ST_ACK   = 4'h4,
        ST_RDATA = 4'h5,
        ST_RACK  = 4'h6,
        ST_RNEXT = 4'h7
    } ifa_state_t;

endpackage : ifa_pkg

// file: hw/ifa_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are plain levels from outside the clk_sys domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module ifa_sync
#(
    parameter int unsigned     W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
)
(
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    input  wire logic [W-1:0]  d_in,
    output var  logic [W-1:0]  q_out
);

    logic [W-1:0] stage1;

    generate
        if (W < 1)
        begin : g_bad_w
            $error("ifa_sync needs at least one lane");
        end
        for (genvar i = 0; i < W; i++)
        begin : g_lane
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                begin
                    stage1[i] <= RST_VAL[i];
                    q_out[i]  <= RST_VAL[i];
                end
                else
                begin
                    stage1[i] <= d_in[i];
                    q_out[i]  <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : ifa_sync
`default_nettype wire

// file: hw/ifa_byte_mem.sv
// Purpose: byte array held in flip-flops, one write port, one read port
// Assumes: write is taken on the clock edge, read is combinational
// Notes:   no reset, contents stand in for nonvolatile storage
`timescale 1ns/10ps
`default_nettype none
module ifa_byte_mem
#(
    parameter int unsigned AW = 11,
    parameter int unsigned DW = 8
)
(
    input  wire logic          clk_sys,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    generate
        if (AW < 1 || AW > 16 || DW < 1)
        begin : g_bad_size
            $error("ifa_byte_mem size out of range");
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule : ifa_byte_mem
`default_nettype wire

// file: hw/ifa_slave.sv
// Purpose: two-wire serial slave giving byte access to a 2048 x 8 array
// Assumes: bus pins are asynchronous, clk_sys is much faster than scl
// Notes:   sda is open drain, sda_out stays low and sda_oe pulls the line
//
// Summary of operation
// - stop condition aborts any operation and returns to idle.
// - start condition at any time aborts and awaits a new slave address.
// - sda stable while scl high except start/stop; bits sampled scl high.
// - ninth slot is acknowledge; receiver pulls sda low to acknowledge.
// - no-acknowledge ends the current operation.
// - first byte after start is the slave address.
// - upper nibble of slave address must match the device-type code.
// - slave address bits 3..1 choose the 256-byte block, top address bits.
// - slave address bit 0 high means read, low means write.
// - write sends one word-address byte, joined below page bits, latched.
// - read takes page bits and keeps low eight latched address bits.
// - address latch increments after each data byte, before acknowledge.
// - address latch wraps from top location to zero.
// - no limit on bytes per operation.
// - read drives eight bits, then acknowledge continues, nack ends.
// - write takes eight bits then the device acknowledges.
// - every byte is sent most significant bit first.
// - array written at eighth data bit; earlier start/stop leaves it intact.
// - no busy period; matching address probes always acknowledged.
// - protect high: data bytes not acknowledged, address not incremented.
// - read data shifted out on scl falls, bits captured on rises.
// - protect input low or floating means writable.
`timescale 1ns/10ps
`default_nettype none
module ifa_slave
    import ifa_pkg::*;
#(
    parameter logic [ifa_pkg::TYPE_W-1:0] TYPE_CODE = ifa_pkg::TYPE_CODE_DEFAULT
)
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output var  logic                       sda_out,
    output var  logic                       sda_oe,
    input  wire logic                       wp_in,
    output var  logic [ifa_pkg::ADDR_W-1:0] byte_addr,
    output var  logic                       busy
);
    import ifa_pkg::*;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic              scl_s;
    logic              sda_s;
    logic              wp_s;
    logic              scl_q;
    logic              sda_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic              bus_cond;

    ifa_state_t        state;
    ifa_state_t        after_ack;
    logic [2:0]        bit_cnt;
    logic [6:0]        shift;
    logic [7:0]        tx;
    logic [ADDR_W-1:0] addr;

    logic [7:0]        byte_in;
    logic              rx_state;
    logic              rx_done;
    logic              type_ok;
    logic              mem_we;
    logic              tx_done;
    logic              addr_inc;
    logic              rd_load;
    logic [7:0]        rdata;

    generate
        if (ADDR_W != PAGE_W + WORD_W || DATA_W != 8)
        begin : g_bad_map
            $error("ifa_slave address map inconsistent");
        end
    endgenerate

    // bus sampling and conditions
    assign pins_raw[LANE_SCL] = scl_in;
    assign pins_raw[LANE_SDA] = sda_in;
    assign pins_raw[LANE_WP]  = wp_in;

    ifa_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RESET)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d_in    (pins_raw),
        .q_out   (pins_s)
    );

    assign scl_s = pins_s[LANE_SCL];
    assign sda_s = pins_s[LANE_SDA];
    // a floating pin is expected to be pulled low outside; high only protects
    assign wp_s  = pins_s[LANE_WP];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s && !scl_q;
    assign scl_fall  = !scl_s && scl_q;
    // sda moving while scl stays high can only be a start or a stop
    assign start_det = scl_s && scl_q && sda_q && !sda_s;
    assign stop_det  = scl_s && scl_q && !sda_q && sda_s;
    assign bus_cond  = start_det || stop_det;

    // byte decode
    assign byte_in  = {shift, sda_s};
    assign rx_state = (state == ST_DEV) || (state == ST_WORD) || (state == ST_WDATA);
    assign rx_done  = rx_state && scl_rise && (bit_cnt == BIT_LAST) && !bus_cond;
    assign type_ok  = (byte_in[TYPE_MSB:TYPE_LSB] == TYPE_CODE);
    assign mem_we   = (state == ST_WDATA) && rx_done && !wp_s;
    assign tx_done  = (state == ST_RDATA) && scl_fall && (bit_cnt == BIT_LAST) && !bus_cond;
    assign addr_inc = mem_we || tx_done;
    assign rd_load  = scl_fall && !bus_cond &&
                      (((state == ST_ACK) && sda_oe && (after_ack == ST_RDATA)) ||
                       (state == ST_RNEXT));

    ifa_byte_mem #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_mem (
        .clk_sys (clk_sys),
        .we      (mem_we),
        .waddr   (addr),
        .wdata   (byte_in),
        .raddr   (addr),
        .rdata   (rdata)
    );

    // protocol sequencer
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state     <= ST_IDLE;
            after_ack <= ST_IDLE;
        end
        else if (stop_det)
        begin
            state <= ST_IDLE;
        end
        else if (start_det)
        begin
            state <= ST_DEV;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    state <= ST_IDLE;
                end
                ST_DEV:
                begin
                    if (rx_done)
                    begin
                        // mismatch: stay off the bus until the next start
                        if (!type_ok)
                        begin
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            // no busy period, a matching probe is always acknowledged
                            state     <= ST_ACK;
                            after_ack <= byte_in[RW_BIT] ? ST_RDATA : ST_WORD;
                        end
                    end
                end
                ST_WORD:
                begin
                    if (rx_done)
                    begin
                        state     <= ST_ACK;
                        after_ack <= ST_WDATA;
                    end
                end
                ST_WDATA:
                begin
                    if (rx_done)
                    begin
                        state     <= wp_s ? ST_IDLE : ST_ACK;
                        after_ack <= ST_WDATA;
                    end
                end
                ST_ACK:
                begin
                    // the fall that ends the ninth clock hands over
                    if (scl_fall && sda_oe)
                    begin
                        state <= after_ack;
                    end
                end
                ST_RDATA:
                begin
                    if (tx_done)
                    begin
                        state <= ST_RACK;
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        state <= sda_s ? ST_IDLE : ST_RNEXT;
                    end
                end
                ST_RNEXT:
                begin
                    if (scl_fall)
                    begin
                        state <= ST_RDATA;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // bit counter, shared by receive and transmit
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || bus_cond)
        begin
            bit_cnt <= BIT_FIRST;
        end
        else if (rx_state && scl_rise)
        begin
            bit_cnt <= bit_cnt + 3'h1;
        end
        else if ((state == ST_RDATA) && scl_fall)
        begin
            bit_cnt <= bit_cnt + 3'h1;
        end
        else if (rd_load)
        begin
            bit_cnt <= BIT_FIRST;
        end
    end

    // receive shifter, captured on scl rises
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            shift <= 7'h00;
        end
        else if (rx_state && scl_rise && !bus_cond)
        begin
            shift <= byte_in[6:0];
        end
    end

    // transmit shifter, msb leaves first
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            tx <= 8'hFF;
        end
        else if (rd_load)
        begin
            tx <= {rdata[6:0], 1'b1};
        end
        else if ((state == ST_RDATA) && scl_fall && !bus_cond)
        begin
            tx <= {tx[6:0], 1'b1};
        end
    end

    // address latch
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            addr <= ADDR_RESET;
        end
        else if ((state == ST_DEV) && rx_done && type_ok)
        begin
            // page bits replace the top, low byte carries over for reads
            addr <= {byte_in[PAGE_MSB:PAGE_LSB], addr[WORD_W-1:0]};
        end
        else if ((state == ST_WORD) && rx_done)
        begin
            addr <= {addr[ADDR_W-1:WORD_W], byte_in};
        end
        else if (addr_inc)
        begin
            addr <= addr + ADDR_ONE;
        end
    end

    // open-drain data driver
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || bus_cond)
        begin
            sda_oe <= 1'b0;
        end
        else if (state == ST_ACK && scl_fall)
        begin
            if (!sda_oe)
            begin
                sda_oe <= 1'b1;
            end
            else
            begin
                sda_oe <= rd_load && !rdata[7];
            end
        end
        else if (rd_load)
        begin
            sda_oe <= !rdata[7];
        end
        else if ((state == ST_RDATA) && scl_fall)
        begin
            // after the eighth bit the line is freed for the master's answer
            sda_oe <= tx_done ? 1'b0 : !tx[7];
        end
        else if (state == ST_IDLE)
        begin
            sda_oe <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sda_out   <= 1'b0;
            byte_addr <= ADDR_RESET;
            busy      <= 1'b0;
        end
        else
        begin
            sda_out   <= 1'b0;
            byte_addr <= addr;
            busy      <= (state != ST_IDLE);
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_nack_seen;
        (state == ST_RACK) && scl_rise && sda_s && !bus_cond;
    endsequence

    sequence s_ack_slot_open;
        (state == ST_ACK) && !sda_oe && scl_fall && !bus_cond;
    endsequence

    a_stop_idle: assert property (stop_det |=> (state == ST_IDLE) && !sda_oe)
        else $error("stop did not return to idle");
    a_start_addr: assert property (start_det |=> (state == ST_DEV) && (bit_cnt == BIT_FIRST))
        else $error("start did not await slave address");
    a_type_reject: assert property ((state == ST_DEV) && rx_done && !type_ok
        |=> (state == ST_IDLE) ##1 !sda_oe)
        else $error("mismatched type code handled wrongly");
    a_protect_hold: assert property ((state == ST_WDATA) && rx_done && wp_s
        |-> !mem_we ##1 (addr == $past(addr)) && (state == ST_IDLE))
        else $error("protected write changed array or address");
    a_addr_step: assert property (addr_inc && (addr != ADDR_TOP) |=> addr == $past(addr) + ADDR_ONE)
        else $error("address did not step by one");
    a_addr_wrap: assert property (addr_inc && (addr == ADDR_TOP) |=> addr == ADDR_RESET)
        else $error("address did not wrap to zero");
    a_write_eighth: assert property (mem_we |-> (state == ST_WDATA) && scl_rise && (bit_cnt == BIT_LAST))
        else $error("array write outside eighth bit");
    a_ack_drive: assert property (s_ack_slot_open |=> sda_oe && (state == ST_ACK))
        else $error("acknowledge not driven");
    a_read_nack: assert property (s_nack_seen |=> (state == ST_IDLE) && !sda_oe [*2])
        else $error("read not ended on no-acknowledge");
    a_drive_on_fall: assert property ($rose(sda_oe) |-> $past(scl_fall))
        else $error("sda driven away from scl fall");

endmodule : ifa_slave
`default_nettype wire

// file: tb/ifa_master_model.sv
// Purpose: behavioural two-wire bus master facing the slave pins
// Assumes: sda has a pull-up; the line level is resolved here
// Notes:   scl high 8 and low 10 clk_sys, sda moves 5 clk after scl fall
`timescale 1ns/10ps
`default_nettype none
module ifa_master_model
(
    input  wire logic clk_sys,
    input  wire logic sda_oe,
    output var  logic scl_in,
    output var  logic sda_in
);
    logic m_oe = 1'b0;

    // wired-and: released line floats high
    always_comb sda_in = !(m_oe | sda_oe);
    initial scl_in = 1'b1;

    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task start();
        m_oe = 1'b0;
        tick(5);
        scl_in = 1'b1;
        tick(8);
        m_oe = 1'b1;
        tick(8);
        scl_in = 1'b0;
    endtask : start

    task stop();
        tick(5);
        m_oe = 1'b1;
        tick(5);
        scl_in = 1'b1;
        tick(8);
        m_oe = 1'b0;
        tick(10);
    endtask : stop

    // sda only moves while scl is low
    task send_bit(input logic b);
        tick(5);
        m_oe = !b;
        tick(5);
        scl_in = 1'b1;
        tick(8);
        scl_in = 1'b0;
    endtask : send_bit

    task recv_bit(output logic b);
        m_oe = 1'b0;
        tick(10);
        scl_in = 1'b1;
        tick(4);
        b = sda_in;
        tick(4);
        scl_in = 1'b0;
    endtask : recv_bit

    task write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            send_bit(d[i]);
        end
        recv_bit(b);
        ack = !b;
    endtask : write_byte

    // last byte wanted is left unacknowledged by the caller
    task read_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
        begin
            recv_bit(d[i]);
        end
        send_bit(!ack);
    endtask : read_byte
endmodule : ifa_master_model
`default_nettype wire

// file: tb/tb_ifa_slave.sv
// Purpose: self-checking bench for the two-wire byte-array slave
// Assumes: default device-type code, master model drives the bus
// Notes:   array is not reset, so reads only touch written places
`timescale 1ns/10ps
`default_nettype none
module tb_ifa_slave;
    import ifa_pkg::*;

    logic              clk_sys     = 1'b0;
    logic              rst_b       = 1'b0;
    logic              wp_in       = 1'b0;
    logic              scl_in;
    logic              sda_in;
    logic              sda_out;
    logic              sda_oe;
    logic [ADDR_W-1:0] byte_addr;
    logic              busy;
    logic              ack;
    logic [7:0]        rd;
    int                failures    = 0;
    int                check_count = 0;
    localparam logic [3:0] TY = TYPE_CODE_DEFAULT;

    always #5 clk_sys = ~clk_sys;

    ifa_slave ifa_slave_inst
    (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe    (sda_oe),
        .wp_in     (wp_in),
        .byte_addr (byte_addr),
        .busy      (busy)
    );

    ifa_master_model ifa_master_model_inst
    (
        .clk_sys (clk_sys),
        .sda_oe  (sda_oe),
        .scl_in  (scl_in),
        .sda_in  (sda_in)
    );

    task give_verdict();
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task check(input logic [10:0] got, input logic [10:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check

    task op(input logic [3:0] ty, input logic [2:0] pg, input logic rw, input logic exp_ack);
        ifa_master_model_inst.start();
        ifa_master_model_inst.write_byte({ty, pg, rw}, ack);
        check({10'h000, ack}, {10'h000, exp_ack}, "address ack");
        check({10'h000, busy}, {10'h000, exp_ack}, "busy after address");
    endtask : op

    task wr(input logic [7:0] d, input logic exp_ack, input logic [10:0] exp_addr);
        ifa_master_model_inst.write_byte(d, ack);
        check({10'h000, ack}, {10'h000, exp_ack}, "write ack");
        check(byte_addr, exp_addr, "address after write");
    endtask : wr

    task rd_chk(input logic a, input logic [7:0] exp, input logic [10:0] exp_addr);
        ifa_master_model_inst.read_byte(a, rd);
        check({3'h0, rd}, {3'h0, exp}, "read data");
        check(byte_addr, exp_addr, "address after read");
    endtask : rd_chk

    task idle_chk();
        check({8'h00, sda_out, busy, sda_oe}, 11'h000, "not idle");
    endtask : idle_chk

    task partial_bits();
        for (int i = 0; i < 4; i++)
        begin
            ifa_master_model_inst.send_bit(1'b0);
        end
    endtask : partial_bits

    initial
    begin
        // tests need about 5000 clk_sys; four times that is ample
        #200_000;
        failures++;
        give_verdict();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1;
        check({8'h00, sda_out, busy, sda_oe}, 11'h000, "outputs in reset");
        check(byte_addr, 11'h000, "address in reset");
        rst_b = 1'b1;
        ifa_master_model_inst.tick(4);
        // sequential write over the top location
        op(TY, 3'h7, 1'b0, 1'b1);
        wr(8'hFE, 1'b1, 11'h7FE);
        wr(8'hA5, 1'b1, 11'h7FF);
        wr(8'h3C, 1'b1, 11'h000);
        wr(8'h81, 1'b1, 11'h001);
        // probe straight after a write
        op(TY, 3'h7, 1'b0, 1'b1);
        ifa_master_model_inst.stop();
        idle_chk();
        // set address, restart as read
        op(TY, 3'h7, 1'b0, 1'b1);
        wr(8'hFE, 1'b1, 11'h7FE);
        op(TY, 3'h7, 1'b1, 1'b1);
        rd_chk(1'b1, 8'hA5, 11'h7FF);
        rd_chk(1'b1, 8'h3C, 11'h000);
        rd_chk(1'b0, 8'h81, 11'h001);
        ifa_master_model_inst.tick(10);
        idle_chk();
        ifa_master_model_inst.stop();
        // wrong device-type nibble
        op(4'h3, 3'h0, 1'b0, 1'b0);
        ifa_master_model_inst.tick(10);
        idle_chk();
        ifa_master_model_inst.stop();
        // write, then protected overwrite
        op(TY, 3'h0, 1'b0, 1'b1);
        wr(8'h10, 1'b1, 11'h010);
        wr(8'h11, 1'b1, 11'h011);
        ifa_master_model_inst.stop();
        wp_in = 1'b1;
        op(TY, 3'h0, 1'b0, 1'b1);
        wr(8'h10, 1'b1, 11'h010);
        wr(8'h55, 1'b0, 11'h010);
        ifa_master_model_inst.stop();
        wp_in = 1'b0;
        // partial byte ended by stop must not write
        op(TY, 3'h0, 1'b0, 1'b1);
        wr(8'h10, 1'b1, 11'h010);
        partial_bits();
        ifa_master_model_inst.stop();
        idle_chk();
        // partial byte ended by start must not write either
        op(TY, 3'h0, 1'b0, 1'b1);
        wr(8'h10, 1'b1, 11'h010);
        partial_bits();
        op(TY, 3'h0, 1'b1, 1'b1);
        rd_chk(1'b0, 8'h11, 11'h011);
        ifa_master_model_inst.stop();
        idle_chk();
        give_verdict();
    end
endmodule : tb_ifa_slave
`default_nettype wire
